// [rtl/dpt_params.svh]
// constants for the drive parameter telegram slave
`ifndef DPT_PARAMS_SVH
`define DPT_PARAMS_SVH
`define DPT_PNU_MSB 10
`define DPT_CODE_LSB 12
`define DPT_CODE_MSB 15
`define DPT_TYPE_TEXT 4'h9
`define DPT_TEXT_WRITE_IND 16'h0500
`define DPT_PROFILE_CTRL 8'h01
`define DPT_CW_BRAKE_N 2
`define DPT_CW_COAST_N 3
`define DPT_CW_QSTOP_N 4
`define DPT_FAULT_NO_PARAM 32'h00000000
`define DPT_FAULT_NO_WRITE 32'h00000001
`define DPT_FAULT_TYPE 32'h00000005
`define DPT_DATA_W 32
`endif

// [rtl/dpt_pkg.sv]
// types for the drive parameter telegram slave
package dpt_pkg;
   typedef enum logic [3:0] {
      DPT_CMD_NONE = 4'h0,
      DPT_CMD_READ = 4'h1,
      DPT_CMD_WR_W = 4'h2,
      DPT_CMD_WR_D = 4'h3,
      DPT_CMD_WR_DE = 4'hD,
      DPT_CMD_WR_WE = 4'hE,
      DPT_CMD_TEXT = 4'hF
   } dpt_cmd_t;
   typedef enum logic [3:0] {
      DPT_RSP_NONE = 4'h0,
      DPT_RSP_WORD = 4'h1,
      DPT_RSP_DWORD = 4'h2,
      DPT_RSP_FAIL = 4'h7,
      DPT_RSP_TEXT = 4'hF
   } dpt_rsp_t;
   typedef enum logic [1:0] {
      DPT_ST_IDLE = 2'b00,
      DPT_ST_LOOK = 2'b01,
      DPT_ST_DONE = 2'b10
   } dpt_state_t;
endpackage

// [rtl/dpt_slave.sv]
// parameter and process block interpreter of the telegram slave
//
// Contract
// - bits 0-10 select the parameter
// - only index low byte is used (the text write check compares all 16 bits with 0500)
// - value field is two words
// - read returns current value
// - enumerated options written as ordinal
// - text served only for type 9
// - text frame length from second byte
// - index tells text read from write
// - data type codes 3-7 and 9
// - integers scaled by conversion index
// - process block: control word, reference
// - control bits valid for profile 1
// - bits 01/00 pick preset reference
// - bit 02 low brakes with DC
// - bit 03 low coasts the motor
// - bit 04 low quick stops
// - selection parameters gate digital inputs
// - bits 12-15 carry command and response
// - failures answer 0111 with reason
// - check byte is running exclusive-or
// - address byte echoed unchanged
`timescale 1ns/100ps
`default_nettype none
`include "dpt_params.svh"
module dpt_slave #(
   parameter int DATA_W = `DPT_DATA_W
) (
   input wire logic clk,
   input wire logic reset,
   // request telegram fields, one pulse per telegram
   input wire logic req_valid,
   input wire logic [7:0] req_addr,
   input wire logic [7:0] telegram_length_byte,
   input wire logic [15:0] param_id_word,
   input wire logic [15:0] param_subindex_field,
   input wire logic [31:0] param_value_field,
   input wire logic [15:0] control_status_word,
   input wire logic [15:0] reference_word,
   // byte stream for check byte
   input wire logic rx_byte_valid,
   input wire logic rx_frame_start,
   input wire logic [7:0] rx_byte,
   // parameter store lookup, answers in the same cycle as store_rd
   output logic store_rd,
   output logic store_wr,
   output logic store_eeprom,
   output logic store_text_wr,
   output logic [10:0] store_number,
   output logic [7:0] store_index,
   output logic [31:0] store_wdata,
   input wire logic store_exists,
   input wire logic store_writable,
   input wire logic [3:0] store_type,
   input wire logic [31:0] store_rdata,
   // drive settings and digital inputs
   input wire logic [7:0] profile_sel,
   input wire logic [1:0] preset_sel_mode,
   input wire logic [1:0] brake_sel_mode,
   input wire logic [1:0] coast_sel_mode,
   input wire logic [1:0] din_preset,
   input wire logic din_brake_n,
   input wire logic din_coast_n,
   // response telegram
   output logic rsp_valid,
   output logic [7:0] rsp_addr,
   output logic [15:0] rsp_id_word,
   output logic [15:0] rsp_subindex,
   output logic [31:0] rsp_value,
   output logic [7:0] rsp_length,
   output logic [7:0] running_checksum,
   // drive commands
   output logic [1:0] preset_ref,
   output logic dc_brake,
   output logic coast,
   output logic quick_stop,
   output logic [15:0] reference
);
   if (DATA_W != 32) begin : g_width_check
      $error("dpt_slave: value field must be 32 bits");
   end
   // ----------------------------------------
   // helpers
   // ----------------------------------------
   // selection mode: 0 digital, 1 bus, 2 and, 3 or (active low stop)
   function automatic logic gate_n(input logic [1:0] mode, input logic bus_n, input logic din_n);
      case (mode)
         2'd0: gate_n = din_n;
         2'd1: gate_n = bus_n;
         2'd2: gate_n = bus_n | din_n;
         default: gate_n = bus_n & din_n;
      endcase
   endfunction
   // ----------------------------------------
   // check byte accumulator
   // ----------------------------------------
   logic [7:0] next_running_checksum;
   always_comb begin
      next_running_checksum = running_checksum;
      if (rx_frame_start)
         next_running_checksum = 8'h00;
      else if (rx_byte_valid)
         next_running_checksum = running_checksum ^ rx_byte;
   end
   always_ff @(posedge clk) begin
      if (reset) running_checksum <= 8'h00;
      else running_checksum <= next_running_checksum;
   end
   // ----------------------------------------
   // parameter command interpreter
   // ----------------------------------------
   dpt_pkg::dpt_state_t state, next_state;
   logic [15:0] id_q, next_id_q, ind_q, next_ind_q;
   logic [31:0] val_q, next_val_q;
   logic [7:0] addr_q, next_addr_q, len_q, next_len_q;
   logic next_store_rd, next_store_wr, next_store_eeprom, next_store_text_wr;
   logic next_rsp_valid;
   logic [15:0] next_rsp_id_word, next_rsp_subindex;
   logic [31:0] next_rsp_value;
   logic [7:0] next_rsp_addr, next_rsp_length;
   dpt_pkg::dpt_cmd_t cmd;
   logic [3:0] rcode;
   logic [31:0] rval;
   assign cmd = dpt_pkg::dpt_cmd_t'(id_q[`DPT_CODE_MSB:`DPT_CODE_LSB]);
   always_comb begin
      next_state = state;
      next_id_q = id_q;
      next_ind_q = ind_q;
      next_val_q = val_q;
      next_addr_q = addr_q;
      next_len_q = len_q;
      next_store_rd = 1'b0;
      next_store_wr = 1'b0;
      next_store_eeprom = 1'b0;
      next_store_text_wr = 1'b0;
      next_rsp_valid = 1'b0;
      next_rsp_id_word = rsp_id_word;
      next_rsp_subindex = rsp_subindex;
      next_rsp_value = rsp_value;
      next_rsp_addr = rsp_addr;
      next_rsp_length = rsp_length;
      rcode = dpt_pkg::DPT_RSP_NONE;
      rval = 32'h00000000;
      case (state)
         dpt_pkg::DPT_ST_IDLE: begin
            if (req_valid) begin
               next_id_q = param_id_word;
               next_ind_q = param_subindex_field;
               next_val_q = param_value_field;
               next_addr_q = req_addr;
               next_len_q = telegram_length_byte;
               next_store_rd = 1'b1;
               next_state = dpt_pkg::DPT_ST_LOOK;
            end
         end
         dpt_pkg::DPT_ST_LOOK: begin
            case (cmd)
               dpt_pkg::DPT_CMD_NONE: rcode = dpt_pkg::DPT_RSP_NONE;
               dpt_pkg::DPT_CMD_READ: begin
                  rval = store_rdata;
                  rcode = (store_type == 4'h4 || store_type == 4'h7) ? dpt_pkg::DPT_RSP_DWORD
                        : dpt_pkg::DPT_RSP_WORD;
               end
               dpt_pkg::DPT_CMD_WR_W, dpt_pkg::DPT_CMD_WR_D,
               dpt_pkg::DPT_CMD_WR_DE, dpt_pkg::DPT_CMD_WR_WE: begin
                  rval = val_q;
                  rcode = (cmd == dpt_pkg::DPT_CMD_WR_W || cmd == dpt_pkg::DPT_CMD_WR_WE)
                        ? dpt_pkg::DPT_RSP_WORD : dpt_pkg::DPT_RSP_DWORD;
               end
               dpt_pkg::DPT_CMD_TEXT: begin
                  rcode = dpt_pkg::DPT_RSP_TEXT;
                  rval = (ind_q == `DPT_TEXT_WRITE_IND) ? val_q : store_rdata;
               end
               default: begin
                  rcode = dpt_pkg::DPT_RSP_FAIL;
                  rval = `DPT_FAULT_NO_PARAM;
               end
            endcase
            if (cmd != dpt_pkg::DPT_CMD_NONE) begin
               if (!store_exists) begin
                  rcode = dpt_pkg::DPT_RSP_FAIL;
                  rval = `DPT_FAULT_NO_PARAM;
               end else if (cmd == dpt_pkg::DPT_CMD_TEXT && store_type != `DPT_TYPE_TEXT) begin
                  rcode = dpt_pkg::DPT_RSP_FAIL;
                  rval = `DPT_FAULT_TYPE;
               end else if (rcode != dpt_pkg::DPT_RSP_FAIL && cmd != dpt_pkg::DPT_CMD_READ
                            && !(cmd == dpt_pkg::DPT_CMD_TEXT && ind_q != `DPT_TEXT_WRITE_IND)
                            && !store_writable) begin
                  rcode = dpt_pkg::DPT_RSP_FAIL;
                  rval = `DPT_FAULT_NO_WRITE;
               end
            end
            if (rcode != dpt_pkg::DPT_RSP_FAIL && cmd != dpt_pkg::DPT_CMD_READ
                && cmd != dpt_pkg::DPT_CMD_NONE) begin
               if (cmd == dpt_pkg::DPT_CMD_TEXT)
                  next_store_text_wr = (ind_q == `DPT_TEXT_WRITE_IND);
               else
                  next_store_wr = 1'b1;
               next_store_eeprom = (cmd == dpt_pkg::DPT_CMD_WR_DE || cmd == dpt_pkg::DPT_CMD_WR_WE);
            end
            next_rsp_id_word = {rcode, id_q[11:0]};
            next_rsp_subindex = ind_q;
            next_rsp_value = rval;
            next_rsp_addr = addr_q;
            next_rsp_length = len_q;
            next_rsp_valid = 1'b1;
            next_state = dpt_pkg::DPT_ST_DONE;
         end
         dpt_pkg::DPT_ST_DONE: next_state = dpt_pkg::DPT_ST_IDLE;
         default: next_state = dpt_pkg::DPT_ST_IDLE;
      endcase
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         state <= dpt_pkg::DPT_ST_IDLE;
         id_q <= 16'h0000;
         ind_q <= 16'h0000;
         val_q <= 32'h00000000;
         addr_q <= 8'h00;
         len_q <= 8'h00;
         store_rd <= 1'b0;
         store_wr <= 1'b0;
         store_eeprom <= 1'b0;
         store_text_wr <= 1'b0;
         rsp_valid <= 1'b0;
         rsp_id_word <= 16'h0000;
         rsp_subindex <= 16'h0000;
         rsp_value <= 32'h00000000;
         rsp_addr <= 8'h00;
         rsp_length <= 8'h00;
      end else begin
         state <= next_state;
         id_q <= next_id_q;
         ind_q <= next_ind_q;
         val_q <= next_val_q;
         addr_q <= next_addr_q;
         len_q <= next_len_q;
         store_rd <= next_store_rd;
         store_wr <= next_store_wr;
         store_eeprom <= next_store_eeprom;
         store_text_wr <= next_store_text_wr;
         rsp_valid <= next_rsp_valid;
         rsp_id_word <= next_rsp_id_word;
         rsp_subindex <= next_rsp_subindex;
         rsp_value <= next_rsp_value;
         rsp_addr <= next_rsp_addr;
         rsp_length <= next_rsp_length;
      end
   end
   // store address follows the held request
   always_ff @(posedge clk) begin
      if (reset) begin
         store_number <= 11'h000;
         store_index <= 8'h00;
         store_wdata <= 32'h00000000;
      end else begin
         store_number <= (req_valid && state == dpt_pkg::DPT_ST_IDLE) ? param_id_word[`DPT_PNU_MSB:0]
                         : store_number;
         store_index <= (req_valid && state == dpt_pkg::DPT_ST_IDLE) ? param_subindex_field[7:0]
                        : store_index;
         store_wdata <= (req_valid && state == dpt_pkg::DPT_ST_IDLE) ? param_value_field : store_wdata;
      end
   end
   // ----------------------------------------
   // process block and control word
   // ----------------------------------------
   logic [1:0] din_preset_m, din_preset_s;
   logic [1:0] din_stop_m, din_stop_s;
   logic [15:0] cw, next_cw, next_reference;
   logic [1:0] next_preset_ref;
   logic next_dc_brake, next_coast, next_quick_stop;
   always_ff @(posedge clk) begin
      if (reset) begin
         din_preset_m <= 2'h0;
         din_preset_s <= 2'h0;
         din_stop_m <= 2'h3;
         din_stop_s <= 2'h3;
      end else begin
         din_preset_m <= din_preset;
         din_preset_s <= din_preset_m;
         din_stop_m <= {din_coast_n, din_brake_n};
         din_stop_s <= din_stop_m;
      end
   end

   always_comb begin
      next_cw = cw;
      next_reference = reference;
      if (req_valid && state == dpt_pkg::DPT_ST_IDLE) begin
         next_cw = control_status_word;
         next_reference = reference_word;
      end
      next_preset_ref = preset_ref;
      next_dc_brake = dc_brake;
      next_coast = coast;
      next_quick_stop = quick_stop;
      if (profile_sel == `DPT_PROFILE_CTRL) begin
         case (preset_sel_mode)
            2'd0: next_preset_ref = din_preset_s;
            2'd1: next_preset_ref = cw[1:0];
            2'd2: next_preset_ref = cw[1:0] & din_preset_s;
            default: next_preset_ref = cw[1:0] | din_preset_s;
         endcase
         next_dc_brake = !gate_n(brake_sel_mode, cw[`DPT_CW_BRAKE_N], din_stop_s[0]);
         next_coast = !gate_n(coast_sel_mode, cw[`DPT_CW_COAST_N], din_stop_s[1]);
         next_quick_stop = !cw[`DPT_CW_QSTOP_N];
      end
   end

   always_ff @(posedge clk) begin
      if (reset) begin
         cw <= 16'h0000;
         reference <= 16'h0000;
         preset_ref <= 2'h0;
         dc_brake <= 1'b0;
         coast <= 1'b1;
         quick_stop <= 1'b0;
      end else begin
         cw <= next_cw;
         reference <= next_reference;
         preset_ref <= next_preset_ref;
         dc_brake <= next_dc_brake;
         coast <= next_coast;
         quick_stop <= next_quick_stop;
      end
   end
endmodule
`default_nettype wire

// [verif/dpt_slave_properties.sv]
// concurrent checks on the telegram slave ports
`timescale 1ns/100ps
`default_nettype none
module dpt_slave_checker #(
   parameter int DATA_W = 32
) (
   input wire logic clk,
   input wire logic reset,
   input wire logic req_valid,
   input wire logic [7:0] req_addr,
   input wire logic [15:0] param_id_word,
   input wire logic [15:0] param_subindex_field,
   input wire logic [15:0] control_status_word,
   input wire logic [7:0] profile_sel,
   input wire logic rx_byte_valid,
   input wire logic rx_frame_start,
   input wire logic [7:0] rx_byte,
   input wire logic store_rd,
   input wire logic store_wr,
   input wire logic [10:0] store_number,
   input wire logic [7:0] store_index,
   input wire logic [3:0] store_type,
   input wire logic rsp_valid,
   input wire logic [7:0] rsp_addr,
   input wire logic [15:0] rsp_id_word,
   input wire logic [7:0] running_checksum,
   input wire logic quick_stop
);
   logic [1:0] cnt, next_cnt;
   logic [15:0] cap_id, next_cap_id, cap_cw, next_cap_cw;
   logic [7:0] cap_addr, next_cap_addr;
   logic taken;
   assign taken = req_valid && (cnt == 2'h0);
   always_comb begin
      next_cnt = taken ? 2'h2 : (cnt != 2'h0 ? cnt - 2'h1 : cnt);
      next_cap_id = taken ? param_id_word : cap_id;
      next_cap_cw = taken ? control_status_word : cap_cw;
      next_cap_addr = taken ? req_addr : cap_addr;
   end
   always_ff @(posedge clk) begin
      cnt <= reset ? 2'h0 : next_cnt;
      cap_id <= next_cap_id;
      cap_cw <= next_cap_cw;
      cap_addr <= next_cap_addr;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_lookup;
      store_rd ##1 rsp_valid;
   endsequence
   answer_timing_a: assert property (taken |=> s_lookup) else $error("answer timing wrong");
   number_fwd_a: assert property (taken |=> store_number == cap_id[10:0]) else $error("number lost");
   index_low_a: assert property (taken |=> store_index == $past(param_subindex_field[7:0]))
      else $error("index byte wrong");
   id_keep_a: assert property (rsp_valid |-> rsp_id_word[11:0] == cap_id[11:0]) else $error("id changed");
   addr_echo_a: assert property (rsp_valid |-> rsp_addr == cap_addr) else $error("address changed");
   rsp_pulse_a: assert property (rsp_valid |=> !rsp_valid) else $error("response too long");
   write_only_a: assert property (store_wr |-> rsp_valid && (cap_id[15:12] inside {4'h2, 4'h3, 4'hD, 4'hE}))
      else $error("stray write");
   read_no_wr_a: assert property (taken && param_id_word[15:12] == 4'h1 |-> ##2 !store_wr)
      else $error("read wrote");
   text_type_a: assert property (rsp_valid && rsp_id_word[15:12] == 4'hF |-> store_type == 4'h9)
      else $error("text on wrong type");
   csum_step_a: assert property (rx_byte_valid && !rx_frame_start |=>
      running_checksum == ($past(running_checksum) ^ $past(rx_byte))) else $error("checksum step");
   qstop_follow_a: assert property (taken && profile_sel == 8'h01 |-> ##[1:3] quick_stop == !cap_cw[4])
      else $error("quick stop wrong");
   qstop_hold_a: assert property (taken && profile_sel != 8'h01 |=> $stable(quick_stop)[*3])
      else $error("quick stop moved");
endmodule
bind dpt_slave dpt_slave_checker #(.DATA_W(DATA_W)) u_dpt_slave_checker (.clk(clk), .reset(reset),
   .req_valid(req_valid), .req_addr(req_addr), .param_id_word(param_id_word),
   .param_subindex_field(param_subindex_field), .control_status_word(control_status_word),
   .profile_sel(profile_sel), .rx_byte_valid(rx_byte_valid), .rx_frame_start(rx_frame_start), .rx_byte(rx_byte),
   .store_rd(store_rd), .store_wr(store_wr), .store_number(store_number), .store_index(store_index),
   .store_type(store_type), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_id_word(rsp_id_word),
   .running_checksum(running_checksum), .quick_stop(quick_stop));
`default_nettype wire

// [verif/dpt_store_model.sv]
// parameter store model answering the slave lookups
`timescale 1ns/100ps
`default_nettype none
module dpt_store_model (
   input wire logic clk,
   input wire logic reset,
   input wire logic store_wr,
   input wire logic [10:0] store_number,
   input wire logic [7:0] store_index,
   input wire logic [31:0] store_wdata,
   output logic store_exists,
   output logic store_writable,
   output logic [3:0] store_type,
   output logic [31:0] store_rdata
);
   logic [31:0] mem [0:3];
   logic [1:0] slot;
   always_comb begin
      store_exists = 1'b1;
      store_writable = 1'b1;
      slot = 2'h3;
      store_type = 4'h9;
      case (store_number)
         11'd207: begin slot = 2'h0; store_type = 4'h6; end
         11'd202: begin slot = 2'h1; store_type = 4'h7; end
         11'd416: begin slot = 2'h2; store_type = 4'h5; end
         11'd615: begin store_writable = 1'b0; store_type = 4'h4; end
         11'd621: store_writable = 1'b0;
         11'd622: slot = 2'h3;
         default: begin store_exists = 1'b0; store_writable = 1'b0; end
      endcase
      // absent parameters answer a fixed pattern with the number in the low bits, never the last value
      store_rdata = store_exists ? mem[slot] + {24'h0, store_index} : {21'h1ABCD, store_number};
   end
   always_ff @(posedge clk) begin
      if (reset) begin
         mem[0] <= 32'h0000000A;
         mem[1] <= 32'h00000000;
         mem[2] <= 32'h00000000;
         mem[3] <= 32'h00000040;
      end else if (store_wr && store_writable) begin
         mem[slot] <= store_wdata;
      end
   end
endmodule
`default_nettype wire

// [verif/drive_parameter_telegram_slave_tb.sv]
// self-checking bench for the telegram slave
`timescale 1ns/100ps
`default_nettype none
module drive_parameter_telegram_slave_tb;
   logic clk = 1'b0, reset = 1'b1, req_valid = 1'b0, rx_byte_valid = 1'b0, rx_frame_start = 1'b0;
   logic din_brake_n = 1'b1, din_coast_n = 1'b1;
   logic [7:0] req_addr = 8'h00, telegram_length_byte = 8'h00, rx_byte = 8'h00, profile_sel = 8'h01;
   logic [15:0] param_id_word = 16'h0000, param_subindex_field = 16'h0000;
   logic [15:0] control_status_word = 16'h001C, reference_word = 16'h0000;
   logic [31:0] param_value_field = 32'h00000000;
   logic [1:0] preset_sel_mode = 2'h1, brake_sel_mode = 2'h1, coast_sel_mode = 2'h1, din_preset = 2'h0;
   logic store_rd, store_wr, store_eeprom, store_text_wr, store_exists, store_writable;
   logic rsp_valid, dc_brake, coast, quick_stop;
   logic [10:0] store_number;
   logic [7:0] store_index, rsp_addr, rsp_length, running_checksum;
   logic [31:0] store_wdata, store_rdata, rsp_value;
   logic [15:0] rsp_id_word, rsp_subindex, reference;
   logic [3:0] store_type;
   logic [1:0] preset_ref;
   int n_errors = 0, compares = 0;
   always #5 clk = ~clk;
   dpt_slave u_dpt_slave (.clk(clk), .reset(reset), .req_valid(req_valid), .req_addr(req_addr),
      .telegram_length_byte(telegram_length_byte), .param_id_word(param_id_word),
      .param_subindex_field(param_subindex_field), .param_value_field(param_value_field),
      .control_status_word(control_status_word), .reference_word(reference_word), .rx_byte_valid(rx_byte_valid),
      .rx_frame_start(rx_frame_start), .rx_byte(rx_byte), .store_rd(store_rd), .store_wr(store_wr),
      .store_eeprom(store_eeprom), .store_text_wr(store_text_wr), .store_number(store_number),
      .store_index(store_index), .store_wdata(store_wdata), .store_exists(store_exists),
      .store_writable(store_writable), .store_type(store_type), .store_rdata(store_rdata),
      .profile_sel(profile_sel), .preset_sel_mode(preset_sel_mode), .brake_sel_mode(brake_sel_mode),
      .coast_sel_mode(coast_sel_mode), .din_preset(din_preset), .din_brake_n(din_brake_n),
      .din_coast_n(din_coast_n), .rsp_valid(rsp_valid), .rsp_addr(rsp_addr), .rsp_id_word(rsp_id_word),
      .rsp_subindex(rsp_subindex), .rsp_value(rsp_value), .rsp_length(rsp_length),
      .running_checksum(running_checksum), .preset_ref(preset_ref), .dc_brake(dc_brake), .coast(coast),
      .quick_stop(quick_stop), .reference(reference));
   dpt_store_model u_dpt_store_model (.clk(clk), .reset(reset), .store_wr(store_wr), .store_number(store_number),
      .store_index(store_index), .store_wdata(store_wdata), .store_exists(store_exists),
      .store_writable(store_writable), .store_type(store_type), .store_rdata(store_rdata));
   task automatic finish_test;
      $display("errors=%0d compares=%0d", n_errors, compares);
      if (n_errors == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("Error t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one telegram: drive fields for one cycle, wait for the answer, check it
   task automatic send(input logic [3:0] c, input logic [10:0] n, input logic [15:0] idx, input logic [31:0] v,
      input logic [15:0] cw, input logic [3:0] ec, input logic [31:0] ev);
      int i;
      logic [2:0] ew;
      @(posedge clk);
      req_valid <= 1'b1;
      param_id_word <= {c, 1'b0, n};
      param_subindex_field <= idx;
      param_value_field <= v;
      control_status_word <= cw;
      reference_word <= ~cw;
      req_addr <= {3'h0, n[4:0]};
      telegram_length_byte <= 8'h0E ^ {4'h0, c};
      @(posedge clk);
      req_valid <= 1'b0;
      for (i = 0; i < 5 && rsp_valid !== 1'b1; i++) @(negedge clk);
      if (rsp_valid !== 1'b1) begin
         n_errors++;
         finish_test();
      end
      chk({16'h0, rsp_id_word}, {16'h0, ec, 1'b0, n});
      chk({24'h0, rsp_addr}, {27'h0, n[4:0]});
      chk({24'h0, rsp_length}, {24'h0, 8'h0E ^ {4'h0, c}});
      chk(rsp_value, ev);
      chk({16'h0, rsp_subindex}, {16'h0, idx});
      chk(store_wdata, v);
      ew = {ec != 4'h7 && c inside {4'h2, 4'h3, 4'hD, 4'hE}, ec != 4'h7 && c inside {4'hD, 4'hE},
         ec == 4'hF && idx == 16'h0500};
      chk({29'h0, store_wr, store_eeprom, store_text_wr}, {29'h0, ew});
   endtask
   task automatic rx(input logic st, input logic [7:0] b);
      @(posedge clk);
      rx_frame_start <= st;
      rx_byte_valid <= !st;
      rx_byte <= b;
      @(posedge clk);
      rx_frame_start <= 1'b0;
      rx_byte_valid <= 1'b0;
   endtask
   initial begin
      logic [2:0] kk;
      repeat (2) @(posedge clk);
      reset <= 1'b0;
      @(negedge clk);
      chk({26'h0, rsp_valid, preset_ref, dc_brake, coast, quick_stop}, 32'h00000002);
      send(4'h1, 11'd207, 16'h0000, 32'hFFFFFFFF, 16'h001C, 4'h1, 32'h0000000A);
      send(4'h1, 11'd615, 16'hAB01, 32'h0, 16'h001C, 4'h2, 32'h00000041);
      send(4'hE, 11'd202, 16'h0000, 32'h000003E8, 16'h001C, 4'h1, 32'h000003E8);
      send(4'h1, 11'd202, 16'h0000, 32'h0, 16'h001C, 4'h2, 32'h000003E8);
      send(4'h3, 11'd416, 16'h0000, 32'h00000014, 16'h001C, 4'h2, 32'h00000014);
      send(4'h1, 11'd416, 16'h0000, 32'h0, 16'h001C, 4'h1, 32'h00000014);
      send(4'hD, 11'd207, 16'h0000, 32'h00000064, 16'h001C, 4'h2, 32'h00000064);
      send(4'h2, 11'd207, 16'h0000, 32'h00000055, 16'h001C, 4'h1, 32'h00000055);
      send(4'h2, 11'd615, 16'h0000, 32'h00000005, 16'h001C, 4'h7, 32'h00000001);
      send(4'h1, 11'd100, 16'h0000, 32'h0, 16'h001C, 4'h7, 32'h00000000);
      send(4'hF, 11'd207, 16'h0000, 32'h0, 16'h001C, 4'h7, 32'h00000005);
      send(4'hF, 11'd621, 16'h0000, 32'h0, 16'h001C, 4'hF, 32'h00000040);
      send(4'hF, 11'd622, 16'h0500, 32'h41424344, 16'h001C, 4'hF, 32'h41424344);
      send(4'hF, 11'd621, 16'h0500, 32'h41424344, 16'h001C, 4'h7, 32'h00000001);
      send(4'h4, 11'd207, 16'h0000, 32'h0, 16'h001C, 4'h7, 32'h00000000);
      for (int k = 0; k < 8; k++) begin
         kk = k[2:0];
         send(4'h1, 11'd207, 16'h0000, 32'h0, {11'h0, kk, kk[1:0]}, 4'h1, 32'h00000055);
         chk({27'h0, preset_ref, dc_brake, coast, quick_stop}, {27'h0, kk[1:0], ~kk[0], ~kk[1], ~kk[2]});
         chk({16'h0, reference}, {16'h0, ~{11'h0, kk, kk[1:0]}});
      end
      @(posedge clk);
      profile_sel <= 8'h00;
      send(4'h1, 11'd207, 16'h0000, 32'h0, 16'h0000, 4'h1, 32'h00000055);
      chk({27'h0, preset_ref, dc_brake, coast, quick_stop}, 32'h00000018);
      @(posedge clk);
      profile_sel <= 8'h01;
      preset_sel_mode <= 2'h0;
      brake_sel_mode <= 2'h0;
      coast_sel_mode <= 2'h0;
      din_preset <= 2'h2;
      din_coast_n <= 1'b0;
      repeat (4) @(posedge clk);
      send(4'h1, 11'd207, 16'h0000, 32'h0, 16'h0019, 4'h1, 32'h00000055);
      chk({27'h0, preset_ref, dc_brake, coast, quick_stop}, 32'h00000012);
      @(posedge clk);
      preset_sel_mode <= 2'h3;
      brake_sel_mode <= 2'h2;
      coast_sel_mode <= 2'h3;
      din_brake_n <= 1'b0;
      repeat (4) @(posedge clk);
      send(4'h1, 11'd207, 16'h0000, 32'h0, 16'h001D, 4'h1, 32'h00000055);
      chk({27'h0, preset_ref, dc_brake, coast, quick_stop}, 32'h0000001A);
      @(posedge clk);
      preset_sel_mode <= 2'h2;
      brake_sel_mode <= 2'h3;
      coast_sel_mode <= 2'h2;
      send(4'h1, 11'd207, 16'h0000, 32'h0, 16'h001D, 4'h1, 32'h00000055);
      chk({27'h0, preset_ref, dc_brake, coast, quick_stop}, 32'h00000004);
      rx(1'b1, 8'h00);
      rx(1'b0, 8'h02);
      rx(1'b0, 8'hD6);
      @(negedge clk);
      chk({24'h0, running_checksum}, 32'h000000D4);
      finish_test();
   end
endmodule
`default_nettype wire
